// >>> ptm_period_timer.sv
/*
 * period timer: 8-bit up counter with period compare, prescaler,
 * postscaler, interrupt flag/enable and match output.
 * assumes a register master that reads one cycle after the read strobe,
 * a synchronous active-high reset, and sys_clk as the oscillator clock.
 */
// Local design decision: the plain strobed port.
`timescale 1ns/100ps

module ptm_period_timer (
   input  wire logic                  sys_clk,
   input  wire logic                  srst,
   input  wire ptm_pkg::ptm_bus_req_t busReq,
   output logic [7:0]                 rdData,
   output logic                       irq,
   output logic                       matchPulse,
   output logic [7:0]                 timeBase,
   output logic [7:0]                 periodValue,
   output logic                       pwmUpdate
);

   logic [7:0]        countQ, countD;
   logic [7:0]        periodQ, periodD;
   ptm_pkg::ptm_ctrl_t ctrlQ, ctrlD;
   logic [7:0]        flagsQ, flagsD;
   logic [7:0]        enablesQ, enablesD;
   logic [1:0]        instrQ, instrD;
   logic [3:0]        preQ, preD;
   logic [3:0]        postQ, postD;
   logic [7:0]        rdDataD;
   logic              matchQ, updateQ;

   wire wrCount   = busReq.wr && busReq.addr == ptm_pkg::OFF_COUNT;
   wire wrControl = busReq.wr && busReq.addr == ptm_pkg::OFF_CONTROL;
   wire wrPeriod  = busReq.wr && busReq.addr == ptm_pkg::OFF_PERIOD;
   wire wrFlags   = busReq.wr && busReq.addr == ptm_pkg::OFF_FLAGS;
   wire wrEnables = busReq.wr && busReq.addr == ptm_pkg::OFF_ENABLES;

   wire scalerClr = wrCount || wrControl;

   // instruction clock only runs while counting
   wire instrTick = ctrlQ.run && instrQ == ptm_pkg::INSTR_DIV_LAST;

   wire [3:0] preLast =
      (ctrlQ.preSel == ptm_pkg::PRE_DIV1) ? 4'h0 :
      (ctrlQ.preSel == ptm_pkg::PRE_DIV4) ? ptm_pkg::PRE_LAST_4 :
                                            ptm_pkg::PRE_LAST_16;
   wire preTick = instrTick && preQ == preLast;

   // match against period ends the cycle
   wire atPeriod = countQ == periodQ;
   wire match    = preTick && atPeriod && !scalerClr;

   wire postTick = match && postQ == ctrlQ.postSel;

   always_comb begin
      instrD = scalerClr ? 2'h0 :
               ctrlQ.run ? instrQ + 2'h1 : instrQ;
      preD = preQ;
      if (scalerClr) begin
         preD = 4'h0;
      end else if (instrTick) begin
         preD = (preQ == preLast) ? 4'h0 : preQ + 4'h1;
      end
      postD = postQ;
      if (scalerClr) begin
         postD = 4'h0;
      end else if (match) begin
         postD = postTick ? 4'h0 : postQ + 4'h1;
      end
   end

   always_comb begin
      countD = countQ;
      if (wrCount) begin
         countD = busReq.wdata;
      // wrap or increment on prescaler pulse
      end else if (preTick) begin
         countD = atPeriod ? ptm_pkg::RST_COUNT : countQ + 8'h01;
      end
   end

   assign periodD = wrPeriod ? busReq.wdata : periodQ;
   // control layout; bit 7 is not stored
   // control write does not touch countQ
   assign ctrlD = wrControl ? ptm_pkg::ptm_ctrl_t'(busReq.wdata[6:0])
                            : ctrlQ;
   assign enablesD = wrEnables ? busReq.wdata : enablesQ;

   always_comb begin
      flagsD = flagsQ;
      if (wrFlags) begin
         flagsD = flagsQ & ~busReq.wdata;
      end
      if (postTick) begin
         flagsD[ptm_pkg::EVENT_BIT] = 1'b1;
      end
   end

   assign rdDataD =
      (busReq.addr == ptm_pkg::OFF_COUNT)   ? countQ :
      (busReq.addr == ptm_pkg::OFF_PERIOD)  ? periodQ :
      (busReq.addr == ptm_pkg::OFF_CONTROL) ? {1'b0, ctrlQ} :
      (busReq.addr == ptm_pkg::OFF_FLAGS)   ? flagsQ :
      (busReq.addr == ptm_pkg::OFF_ENABLES) ? enablesQ : 8'h00;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         countQ   <= ptm_pkg::RST_COUNT;
         periodQ  <= ptm_pkg::RST_PERIOD;
         ctrlQ    <= ptm_pkg::RST_CONTROL;
         flagsQ   <= ptm_pkg::RST_FLAGS;
         enablesQ <= ptm_pkg::RST_ENABLES;
         instrQ   <= 2'h0;
         preQ     <= 4'h0;
         postQ    <= 4'h0;
         rdData   <= 8'h00;
         matchQ   <= 1'b0;
         updateQ  <= 1'b0;
      end else begin
         countQ   <= countD;
         periodQ  <= periodD;
         ctrlQ    <= ctrlD;
         flagsQ   <= flagsD;
         enablesQ <= enablesD;
         instrQ   <= instrD;
         preQ     <= preD;
         postQ    <= postD;
         rdData   <= busReq.rd ? rdDataD : 8'h00;
         matchQ   <= match;
         updateQ  <= postTick;
      end
   end

   assign matchPulse  = matchQ;
   assign timeBase    = countQ;
   assign periodValue = periodQ;
   // one update strobe for every PWM user
   assign pwmUpdate   = updateQ;
   assign irq = |(flagsQ & enablesQ & (8'h01 << ptm_pkg::EVENT_BIT));

   a_count_wrap: assert property (@(posedge sys_clk) disable iff (srst)
      preTick && atPeriod && !wrCount |=> countQ == 8'h00)
      else $error("counter did not wrap after period match");

   a_count_inc: assert property (@(posedge sys_clk) disable iff (srst)
      preTick && !atPeriod && !wrCount |=> countQ == $past(countQ) + 8'h01)
      else $error("counter did not increment");

   a_stop_hold: assert property (@(posedge sys_clk) disable iff (srst)
      !ctrlQ.run && !busReq.wr |=> $stable(countQ))
      else $error("counter moved while stopped");

   a_scaler_clr: assert property (@(posedge sys_clk) disable iff (srst)
      scalerClr |=> preQ == 4'h0 && postQ == 4'h0 && instrQ == 2'h0)
      else $error("scaler counts not cleared");

   a_ctrl_keep: assert property (@(posedge sys_clk) disable iff (srst)
      wrControl && !preTick |=> countQ == $past(countQ))
      else $error("control write changed the counter");

   sequence s_run_div1;
      ctrlQ.run && ctrlQ.preSel == 2'b00 && !busReq.wr;
   endsequence
   a_div1_rate: assert property (@(posedge sys_clk) disable iff (srst)
      preTick ##1 s_run_div1 [*4] |-> preTick)
      else $error("divide-by-1 tick spacing wrong");

   a_flag_set: assert property (@(posedge sys_clk) disable iff (srst)
      postTick |=> flagsQ[1])
      else $error("flag not set on postscaled match");

   a_flag_stick: assert property (@(posedge sys_clk) disable iff (srst)
      flagsQ[1] && !wrFlags |=> flagsQ[1])
      else $error("flag dropped without clear");

   a_irq_gate: assert property (@(posedge sys_clk) disable iff (srst)
      irq == (flagsQ[1] && enablesQ[1]))
      else $error("interrupt not gated by enable");

   a_period_rst: assert property (@(posedge sys_clk)
      srst |=> periodQ == 8'hFF && countQ == 8'h00)
      else $error("reset values wrong");

   a_rst_scalers: assert property (@(posedge sys_clk)
      srst |=> preQ == 4'h0 && postQ == 4'h0)
      else $error("scaler counts not cleared by reset");

   // reset clears control, flags and enables
   a_rst_regs: assert property (@(posedge sys_clk)
      srst |=> ctrlQ == 7'h00 && flagsQ == 8'h00 && enablesQ == 8'h00)
      else $error("control, flag or enable reset value wrong");

   a_rst_pulses: assert property (@(posedge sys_clk)
      srst |=> !matchPulse && !pwmUpdate && rdData == 8'h00)
      else $error("outputs not quiet after reset");

   a_count_load: assert property (@(posedge sys_clk) disable iff (srst)
      wrCount |=> countQ == $past(busReq.wdata))
      else $error("counter write not taken");

   a_period_load: assert property (@(posedge sys_clk) disable iff (srst)
      wrPeriod |=> periodQ == $past(busReq.wdata))
      else $error("period write not taken");

   a_period_hold: assert property (@(posedge sys_clk) disable iff (srst)
      !wrPeriod |=> $stable(periodQ))
      else $error("period changed without a write");

   a_ctrl_load: assert property (@(posedge sys_clk) disable iff (srst)
      wrControl |=> ctrlQ == $past(busReq.wdata[6:0]))
      else $error("control write not taken");

   a_enable_load: assert property (@(posedge sys_clk) disable iff (srst)
      wrEnables |=> enablesQ == $past(busReq.wdata))
      else $error("enable write not taken");

   a_read_count: assert property (@(posedge sys_clk) disable iff (srst)
      busReq.rd && busReq.addr == ptm_pkg::OFF_COUNT
      |=> rdData == $past(countQ))
      else $error("counter readback wrong");

   // bit 7 of control reads zero
   a_read_ctrl: assert property (@(posedge sys_clk) disable iff (srst)
      busReq.rd && busReq.addr == ptm_pkg::OFF_CONTROL |=> !rdData[7])
      else $error("control bit 7 read as one");

   // read data only after a strobe
   a_read_idle: assert property (@(posedge sys_clk) disable iff (srst)
      !busReq.rd |=> rdData == 8'h00)
      else $error("read data without a strobe");

   // match goes out one cycle later
   a_match_out: assert property (@(posedge sys_clk) disable iff (srst)
      match |=> matchPulse)
      else $error("match pulse missing");

   a_match_only: assert property (@(posedge sys_clk) disable iff (srst)
      !match |=> !matchPulse)
      else $error("match pulse without a match");

   a_update_out: assert property (@(posedge sys_clk) disable iff (srst)
      postTick |=> pwmUpdate)
      else $error("update strobe missing");

   a_update_only: assert property (@(posedge sys_clk) disable iff (srst)
      !postTick |=> !pwmUpdate)
      else $error("update strobe without postscaled match");

   a_update_flag: assert property (@(posedge sys_clk) disable iff (srst)
      pwmUpdate |-> flagsQ[1])
      else $error("update strobe without flag");

   a_stop_notick: assert property (@(posedge sys_clk) disable iff (srst)
      !ctrlQ.run |-> !preTick)
      else $error("prescaler pulse while stopped");

   a_pre_hold: assert property (@(posedge sys_clk) disable iff (srst)
      !ctrlQ.run && !scalerClr |=> $stable(preQ) && $stable(instrQ))
      else $error("prescaler moved while stopped");

   a_instr_step: assert property (@(posedge sys_clk) disable iff (srst)
      ctrlQ.run && !scalerClr |=> instrQ == $past(instrQ) + 2'h1)
      else $error("instruction divider did not step");

   a_pre_step: assert property (@(posedge sys_clk) disable iff (srst)
      instrTick && preQ != preLast && !scalerClr
      |=> preQ == $past(preQ) + 4'h1)
      else $error("prescaler did not step");

   a_pre_wrap: assert property (@(posedge sys_clk) disable iff (srst)
      preTick && !scalerClr |=> preQ == 4'h0)
      else $error("prescaler did not wrap");

   a_post_hold: assert property (@(posedge sys_clk) disable iff (srst)
      !match && !scalerClr |=> $stable(postQ))
      else $error("postscaler moved without a match");

   a_post_step: assert property (@(posedge sys_clk) disable iff (srst)
      match && !postTick |=> postQ == $past(postQ) + 4'h1)
      else $error("postscaler did not step");

   a_post_wrap: assert property (@(posedge sys_clk) disable iff (srst)
      postTick |=> postQ == 4'h0)
      else $error("postscaler did not wrap");

   a_flag_clr: assert property (@(posedge sys_clk) disable iff (srst)
      wrFlags && busReq.wdata[1] && !postTick |=> !flagsQ[1])
      else $error("flag not cleared by write");

   // flag rises only on postscaled match
   a_flag_only: assert property (@(posedge sys_clk) disable iff (srst)
      !postTick && !flagsQ[1] |=> !flagsQ[1])
      else $error("flag set without postscaled match");

endmodule : ptm_period_timer

// >>> ptm_period_timer_bench.sv
/*
 * self-checking bench for the period timer: register access, reset
 * values, scaler timing, flag and interrupt handling.
 * assumes the design package is compiled first; no partner model.
 */
`timescale 1ns/100ps
module ptm_period_timer_bench;
   logic                  sys_clk = 1'b0;
   logic                  srst    = 1'b1;
   ptm_pkg::ptm_bus_req_t busReq  = '0;
   logic [7:0]            rdData;
   logic [7:0]            timeBase;
   logic [7:0]            periodValue;
   logic                  irq;
   logic                  matchPulse;
   logic                  pwmUpdate;
   int                    miscompares = 0;
   int                    checkCount  = 0;

   ptm_period_timer i_dut (
      .sys_clk     (sys_clk),
      .srst        (srst),
      .busReq      (busReq),
      .rdData      (rdData),
      .irq         (irq),
      .matchPulse  (matchPulse),
      .timeBase    (timeBase),
      .periodValue (periodValue),
      .pwmUpdate   (pwmUpdate)
   );

   always #4 sys_clk = ~sys_clk;

   task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      checkCount++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      busReq.wr <= 1'b0;
   endtask : wr

   // read data is only valid in the cycle after the strobe
   task rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
      @(posedge sys_clk);
      busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      busReq.rd <= 1'b0;
      #1;
      chk(nm, {8'h00, rdData}, {8'h00, exp});
   endtask : rd

   function logic pick(input bit upd);
      return upd ? pwmUpdate : matchPulse;
   endfunction : pick

   // first pulse after a control write may be short, so time the second
   task gap(input bit upd, input logic [15:0] exp, input string nm);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (pick(upd) !== 1'b1 && n < 3000);
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (pick(upd) !== 1'b1 && n < 3000);
      chk(nm, n[15:0], exp);
   endtask : gap

   task tally_and_finish;
      $display("checks %0d, mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      tally_and_finish();
   end

   initial begin
      logic [7:0] addrs [6];
      logic [7:0] rstv  [6];
      addrs = '{ptm_pkg::OFF_COUNT, ptm_pkg::OFF_PERIOD, ptm_pkg::OFF_CONTROL,
                ptm_pkg::OFF_FLAGS, ptm_pkg::OFF_ENABLES, 8'h40};
      rstv  = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd(addrs[i], rstv[i], "reset value");
      end
      chk("period out", {8'h00, periodValue}, 16'h00FF);
      wr(ptm_pkg::OFF_PERIOD, 8'hA5);
      rd(ptm_pkg::OFF_PERIOD, 8'hA5, "period");
      chk("period out", {8'h00, periodValue}, 16'h00A5);
      // stopped counter must hold a written value
      wr(ptm_pkg::OFF_COUNT, 8'h3C);
      repeat (40) @(posedge sys_clk);
      rd(ptm_pkg::OFF_COUNT, 8'h3C, "stopped count");
      wr(ptm_pkg::OFF_CONTROL, 8'h28);
      rd(ptm_pkg::OFF_COUNT, 8'h3C, "count after ctrl");
      rd(ptm_pkg::OFF_CONTROL, 8'h28, "control");
      chk("time base", {8'h00, timeBase}, 16'h003C);
      wr(ptm_pkg::OFF_CONTROL, 8'hFF);
      rd(ptm_pkg::OFF_CONTROL, 8'h7F, "control bit7");
      wr(ptm_pkg::OFF_COUNT, 8'h00);
      wr(ptm_pkg::OFF_PERIOD, 8'h01);
      // two counter steps per match, four clocks per instruction tick
      for (int c = 0; c < 4; c++) begin
         wr(ptm_pkg::OFF_CONTROL, {5'h01, c[1:0]} & 8'h07);
         gap(1'b0, c == 0 ? 16'h0008 : c == 1 ? 16'h0020 : 16'h0080,
             "match gap");
      end
      for (int n = 0; n < 16; n++) begin
         wr(ptm_pkg::OFF_CONTROL, {1'b0, n[3:0], 3'b100});
         gap(1'b1, 16'(8 * (n + 1)), "update gap");
      end
      rd(ptm_pkg::OFF_FLAGS, 8'h02, "flag set");
      chk("irq masked", {15'h0000, irq}, 16'h0000);
      wr(ptm_pkg::OFF_ENABLES, 8'h02);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("irq enabled", {15'h0000, irq}, 16'h0001);
      wr(ptm_pkg::OFF_CONTROL, 8'h00);
      repeat (20) @(posedge sys_clk);
      rd(ptm_pkg::OFF_FLAGS, 8'h02, "flag sticky");
      wr(ptm_pkg::OFF_FLAGS, 8'h02);
      rd(ptm_pkg::OFF_FLAGS, 8'h00, "flag cleared");
      rd(ptm_pkg::OFF_ENABLES, 8'h02, "enables");
      chk("irq cleared", {15'h0000, irq}, 16'h0000);
      tally_and_finish();
   end
endmodule : ptm_period_timer_bench

// >>> ptm_pkg.sv
/*
 * package for the period timer: register offsets, field positions,
 * reset values and bus carrier types.
 * assumes a single 125 MHz system clock and a plain register port.
 */
package ptm_pkg;

   localparam logic [7:0] OFF_FLAGS    = 8'h0C;
   localparam logic [7:0] OFF_COUNT    = 8'h11;
   localparam logic [7:0] OFF_CONTROL  = 8'h12;
   localparam logic [7:0] OFF_ENABLES  = 8'h8C;
   localparam logic [7:0] OFF_PERIOD   = 8'h92;

   localparam int POST_MSB             = 6;
   localparam int POST_LSB             = 3;
   localparam int RUN_BIT              = 2;
   localparam int PRE_MSB              = 1;
   localparam int PRE_LSB              = 0;
   localparam int EVENT_BIT            = 1;

   localparam logic [7:0] RST_COUNT    = 8'h00;
   localparam logic [7:0] RST_PERIOD   = 8'hFF;
   localparam logic [6:0] RST_CONTROL  = 7'h00;
   localparam logic [7:0] RST_FLAGS    = 8'h00;
   localparam logic [7:0] RST_ENABLES  = 8'h00;
   localparam logic [7:0] CONTROL_MASK = 8'h7F;

   // instruction clock is the oscillator divided by four
   localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
   localparam logic [3:0] PRE_LAST_4     = 4'h3;
   localparam logic [3:0] PRE_LAST_16    = 4'hF;

   typedef enum logic [1:0] {
      PRE_DIV1  = 2'b00,
      PRE_DIV4  = 2'b01,
      PRE_DIV16 = 2'b10
   } ptm_pre_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ptm_bus_req_t;

   typedef struct packed {
      logic [3:0] postSel;
      logic       run;
      logic [1:0] preSel;
   } ptm_ctrl_t;

endpackage : ptm_pkg
